// File: verilog/tw_pkg.sv
// Shared constants, types and helpers for the two-wire memory slave and its bus controller
package tw_pkg;
	localparam int TW_CLK_HZ              = 25_000_000;
	localparam int TW_WRITE_CYCLE_TIME_MS = 5;
	// Longest time, so rounded down
	localparam int TW_WRITE_CYCLE_CYC     = TW_WRITE_CYCLE_TIME_MS * (TW_CLK_HZ / 1000);
	localparam int TW_SCL_MAX_KHZ         = 400;
	// Quarter of a serial clock period, rounded up so the rate stays at or under the limit
	localparam int TW_QTR_CYC             = (TW_CLK_HZ + 4 * TW_SCL_MAX_KHZ * 1000 - 1)
	                                        / (4 * TW_SCL_MAX_KHZ * 1000);
	localparam int TW_ADDR_W              = 14;
	localparam int TW_PAGE_W              = 6;
	localparam int TW_PAGE_BYTES          = 64;
	localparam int TW_SEL_W               = 3;
	localparam int TW_CNT_W               = 24;
	localparam int TW_TICK_W              = 8;
	localparam logic [3:0] TW_TYPE_CODE   = 4'ha;
	localparam logic       TW_RW_WRITE    = 1'b0;
	localparam logic [3:0] TW_ACK_SLOT    = 4'h8;
	localparam logic [7:0] TW_ALL_ONES    = 8'hff;
	localparam logic [1:0] TW_HI_PAD      = 2'h0;

	// Byte position within a transfer
	typedef enum logic [1:0] {
		PH_DEV  = 2'h0,
		PH_AHI  = 2'h1,
		PH_ALO  = 2'h3,
		PH_DATA = 2'h2
	} tw_phase_type;

	typedef enum logic [1:0] {
		DS_IDLE = 2'h0,
		DS_RX   = 2'h1,
		DS_ACK  = 2'h3,
		DS_BUSY = 2'h2
	} tw_dev_state_type;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'h0,
		HS_START = 2'h1,
		HS_BIT   = 2'h3,
		HS_STOP  = 2'h2
	} tw_host_state_type;

	typedef enum logic [1:0] {
		OP_WRITE   = 2'h0,
		OP_POLL    = 2'h1,
		OP_RECOVER = 2'h2
	} tw_op_type;

	// Device address word: type pattern, select bits, direction
	function automatic logic [7:0] tw_dev_word(input logic [TW_SEL_W-1:0] sel, input logic rw);
		tw_dev_word = {TW_TYPE_CODE, sel, rw};
	endfunction
endpackage

// File: verilog/tw_bus_if.sv
// Two-wire link between controller and memory slave
`timescale 1ns/10ps
interface tw_bus_if;
	logic scl;
	logic sda;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;

	// Wired line with pull-up: low whenever either side enables its driver
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport device (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe_n
	);

	modport host (
		output scl,
		input  sda,
		output host_sda_o,
		output host_sda_oe_n
	);
endinterface

// File: verilog/tw_device.sv
// Memory-side end: bus conditions, address decode, page buffering, timed write
`timescale 1ns/10ps
module tw_device
	import tw_pkg::*;
#(
	parameter int unsigned WR_CYC = TW_WRITE_CYCLE_CYC
) (
	input  wire logic                 sys_clk,
	input  wire logic                 srst,
	tw_bus_if.device                  bus,
	input  wire logic [TW_SEL_W-1:0]  device_select_pins,
	input  wire logic                 write_protect,
	output logic                      prog_valid,
	output logic [TW_ADDR_W-1:0]      prog_addr,
	output logic [7:0]                prog_data,
	output logic                      busy
);
	typedef struct packed {
		logic                               scl_m;
		logic                               scl_s;
		logic                               scl_p;
		logic                               sda_m;
		logic                               sda_s;
		logic                               sda_p;
		logic                               wp_m;
		logic                               wp_s;
		logic [TW_SEL_W-1:0]                sel_m;
		logic [TW_SEL_W-1:0]                sel_s;
		tw_dev_state_type                   state;
		tw_phase_type                       phase;
		logic [3:0]                         bitcnt;
		logic [7:0]                         shreg;
		logic [TW_ADDR_W-1:0]               addr;
		logic [TW_PAGE_BYTES-1:0][7:0]      pbuf;
		logic [TW_PAGE_BYTES-1:0]           pvalid;
		logic [TW_CNT_W-1:0]                cnt;
		logic                               sda_oe_n;
		logic                               prog_valid;
		logic [TW_ADDR_W-1:0]               prog_addr;
		logic [7:0]                         prog_data;
		logic                               busy;
	} tw_dev_regs_type;

	tw_dev_regs_type q;
	tw_dev_regs_type d;

	logic                  rise;
	logic                  fall;
	logic                  start_c;
	logic                  stop_c;
	logic [TW_PAGE_W-1:0]  slot;

	// Edges and conditions seen only on the second synchroniser stage and its delayed copy
	always_comb begin
		rise    = q.scl_s & ~q.scl_p;
		fall    = ~q.scl_s & q.scl_p;
		start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
		stop_c  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
		slot    = q.cnt[TW_PAGE_W-1:0];
	end

	// Next-state logic for the whole slave
	always_comb begin
		d = q;
		// Pins from another domain go through two flops first
		d.scl_m = bus.scl;
		d.scl_s = q.scl_m;
		d.scl_p = q.scl_s;
		d.sda_m = bus.sda;
		d.sda_s = q.sda_m;
		d.sda_p = q.sda_s;
		d.wp_m  = write_protect;
		d.wp_s  = q.wp_m;
		d.sel_m = device_select_pins;
		d.sel_s = q.sel_m;
		d.prog_valid = 1'b0;

		case (q.state)
			DS_BUSY: begin
				// Bus is not looked at at all until the cycle ends
				if (q.cnt < TW_CNT_W'(TW_PAGE_BYTES)) begin
					// Flush buffered bytes first, one a cycle
					if (q.pvalid[slot]) begin
						d.prog_valid = 1'b1;
						d.prog_addr  = {q.addr[TW_ADDR_W-1:TW_PAGE_W], slot};
						d.prog_data  = q.pbuf[slot];
					end
				end
				if (q.cnt == TW_CNT_W'(WR_CYC - 1)) begin
					d.state  = DS_IDLE;
					d.busy   = 1'b0;
					d.pvalid = '0;
					d.phase  = PH_DEV;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			default: begin
				if (start_c) begin
					// Start restarts framing from any point; a half-sent page is dropped
					d.state    = DS_RX;
					d.phase    = PH_DEV;
					d.bitcnt   = '0;
					d.sda_oe_n = 1'b1;
					d.pvalid   = '0;
				end else if (stop_c) begin
					d.sda_oe_n = 1'b1;
					// Protected writes are acknowledged but never committed
					if (q.phase == PH_DATA && (|q.pvalid) && !q.wp_s) begin
						d.state = DS_BUSY;
						d.busy  = 1'b1;
						d.cnt   = '0;
					end else begin
						d.state  = DS_IDLE;
						d.phase  = PH_DEV;
						d.pvalid = '0;
					end
				end else if (q.state == DS_RX && rise && q.bitcnt < TW_ACK_SLOT) begin
					// Shift in on the rising edge, most significant bit first
					d.shreg  = {q.shreg[6:0], q.sda_s};
					d.bitcnt = q.bitcnt + 1'b1;
				end else if (q.state == DS_RX && fall && q.bitcnt == TW_ACK_SLOT) begin
					// Word complete: decide on acknowledge after the eighth fall
					d.state    = DS_ACK;
					d.sda_oe_n = 1'b0;
					case (q.phase)
						PH_DEV: begin
							// Reads are not served here, so a read word is treated as no match
							if (q.shreg != tw_dev_word(q.sel_s, TW_RW_WRITE)) begin
								d.state    = DS_IDLE;
								d.sda_oe_n = 1'b1;
							end
						end
						PH_AHI: d.addr[TW_ADDR_W-1:8] = q.shreg[TW_ADDR_W-9:0];
						PH_ALO: d.addr[7:0] = q.shreg;
						PH_DATA: begin
							d.pbuf[q.addr[TW_PAGE_W-1:0]]   = q.shreg;
							d.pvalid[q.addr[TW_PAGE_W-1:0]] = 1'b1;
							// Wraps inside the page; page row never moves
							d.addr[TW_PAGE_W-1:0] = q.addr[TW_PAGE_W-1:0] + 1'b1;
						end
						default: d.state = DS_IDLE;
					endcase
				end else if (q.state == DS_ACK && fall) begin
					// Release after the ninth clock falls
					d.sda_oe_n = 1'b1;
					d.state    = DS_RX;
					d.bitcnt   = '0;
					case (q.phase)
						PH_DEV:  d.phase = PH_AHI;
						PH_AHI:  d.phase = PH_ALO;
						default: d.phase = PH_DATA;
					endcase
				end
			end
		endcase

		// Idle levels high on the lines so release does not look like a start
		if (srst) begin
			d          = '0;
			d.scl_m    = 1'b1;
			d.scl_s    = 1'b1;
			d.scl_p    = 1'b1;
			d.sda_m    = 1'b1;
			d.sda_s    = 1'b1;
			d.sda_p    = 1'b1;
			d.sda_oe_n = 1'b1;
			d.state    = DS_IDLE;
			d.phase    = PH_DEV;
		end
	end

	// Single state register
	always_ff @(posedge sys_clk) begin
		q <= d;
	end

	// Outputs straight from flops; data line only ever pulled low
	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = q.sda_oe_n;
	assign prog_valid       = q.prog_valid;
	assign prog_addr        = q.prog_addr;
	assign prog_data        = q.prog_data;
	assign busy             = q.busy;
endmodule

// File: verilog/tw_host.sv
// Controller end: makes the serial clock, sends writes, polls and bus recovery
`timescale 1ns/10ps
module tw_host
	import tw_pkg::*;
#(
	parameter int unsigned QTR_CYC = TW_QTR_CYC
) (
	input  wire logic                 sys_clk,
	input  wire logic                 srst,
	tw_bus_if.host                    bus,
	input  wire logic                 op_valid,
	input  wire tw_op_type            op_kind,
	input  wire logic [TW_SEL_W-1:0]  op_sel,
	input  wire logic [TW_ADDR_W-1:0] op_addr,
	input  wire logic [7:0]           op_count,
	input  wire logic [7:0]           wr_data,
	output logic                      op_ready,
	output logic                      data_take,
	output logic                      op_done,
	output logic                      op_nack
);
	typedef struct packed {
		logic                   sda_m;
		logic                   sda_s;
		tw_host_state_type      state;
		logic [TW_TICK_W-1:0]   tick;
		logic [1:0]             qtr;
		logic [3:0]             bitn;
		logic [7:0]             shreg;
		tw_phase_type           phase;
		logic [7:0]             remaining;
		tw_op_type              kind;
		logic [TW_SEL_W-1:0]    sel;
		logic [TW_ADDR_W-1:0]   addr;
		logic                   rec;
		logic                   acked;
		logic                   scl;
		logic                   sda_oe_n;
		logic                   ready;
		logic                   take;
		logic                   done;
		logic                   nack;
	} tw_host_regs_type;

	tw_host_regs_type q;
	tw_host_regs_type d;
	logic             qend;
	logic [7:0]       nbyte;
	logic             load;

	always_comb begin
		d = q;
		d.sda_m = bus.sda;
		d.sda_s = q.sda_m;
		d.take  = 1'b0;
		d.done  = 1'b0;
		nbyte   = '0;
		load    = 1'b0;
		// Quarter-period divider keeps the clock at or under the limit
		qend    = q.tick == TW_TICK_W'(QTR_CYC - 1);
		if (q.state != HS_IDLE) begin
			d.tick = qend ? '0 : q.tick + 1'b1;
			if (qend) begin
				d.qtr = q.qtr + 1'b1;
			end
		end
		case (q.state)
			HS_IDLE: begin
				if (op_valid) begin
					d.kind      = op_kind;
					d.sel       = op_sel;
					d.addr      = op_addr;
					d.remaining = op_count;
					d.rec       = 1'b0;
					d.nack      = 1'b0;
					d.ready     = 1'b0;
					d.state     = HS_START;
					d.sda_oe_n  = 1'b1;
				end
			end
			HS_START: begin
				// Data falls only in the high half of the clock
				if (qend && q.qtr == 2'h0) d.scl = 1'b1;
				if (qend && q.qtr == 2'h1) d.sda_oe_n = 1'b0;
				if (qend && q.qtr == 2'h2) d.scl = 1'b0;
				if (qend && q.qtr == 2'h3) begin
					if (q.kind == OP_RECOVER && q.rec) begin
						d.state    = HS_STOP;
						d.sda_oe_n = 1'b0;
					end else begin
						load  = 1'b1;
						nbyte = (q.kind == OP_RECOVER) ? TW_ALL_ONES : tw_dev_word(q.sel, TW_RW_WRITE);
						d.phase = PH_DEV;
					end
				end
			end
			HS_BIT: begin
				if (qend && q.qtr == 2'h0) d.scl = 1'b1;
				if (qend && q.qtr == 2'h1) d.acked = ~q.sda_s;
				if (qend && q.qtr == 2'h2) d.scl = 1'b0;
				if (qend && q.qtr == 2'h3) begin
					if (q.bitn != TW_ACK_SLOT) begin
						d.bitn  = q.bitn + 1'b1;
						d.shreg = {q.shreg[6:0], 1'b1};
						// Ninth slot released so the slave can answer
						d.sda_oe_n = (q.bitn == TW_ACK_SLOT - 1'b1) ? 1'b1 : q.shreg[6];
					end else if (q.kind == OP_RECOVER) begin
						d.rec      = 1'b1;
						d.state    = HS_START;
						d.sda_oe_n = 1'b1;
					end else if (!q.acked || q.kind == OP_POLL || (q.phase != PH_DEV && q.phase != PH_AHI
					             && q.remaining == '0)) begin
						// No answer, poll result known, or page sent: finish with stop
						d.nack     = ~q.acked;
						d.state    = HS_STOP;
						d.sda_oe_n = 1'b0;
					end else begin
						load = 1'b1;
						case (q.phase)
							PH_DEV: begin
								nbyte   = {TW_HI_PAD, q.addr[TW_ADDR_W-1:8]};
								d.phase = PH_AHI;
							end
							PH_AHI: begin
								nbyte   = q.addr[7:0];
								d.phase = PH_ALO;
							end
							default: begin
								nbyte       = wr_data;
								d.take      = 1'b1;
								d.remaining = q.remaining - 1'b1;
								d.phase     = PH_DATA;
							end
						endcase
					end
				end
			end
			HS_STOP: begin
				if (qend && q.qtr == 2'h0) d.scl = 1'b1;
				if (qend && q.qtr == 2'h1) d.sda_oe_n = 1'b1;
				if (qend && q.qtr == 2'h3) begin
					d.state = HS_IDLE;
					d.ready = 1'b1;
					d.done  = 1'b1;
				end
			end
			default: d.state = HS_IDLE;
		endcase
		// Load a new byte and present its first bit while the clock is low
		if (load) begin
			d.shreg    = nbyte;
			d.bitn     = '0;
			d.state    = HS_BIT;
			d.sda_oe_n = nbyte[7];
		end
		if (srst) begin
			d          = '0;
			d.sda_m    = 1'b1;
			d.sda_s    = 1'b1;
			d.scl      = 1'b1;
			d.sda_oe_n = 1'b1;
			d.ready    = 1'b1;
			d.state    = HS_IDLE;
			d.phase    = PH_DEV;
			d.kind     = OP_WRITE;
		end
	end

	always_ff @(posedge sys_clk) begin
		q <= d;
	end

	assign bus.scl           = q.scl;
	assign bus.host_sda_o    = 1'b0;
	assign bus.host_sda_oe_n = q.sda_oe_n;
	assign op_ready          = q.ready;
	assign data_take         = q.take;
	assign op_done           = q.done;
	assign op_nack           = q.nack;
endmodule

// File: testbench/tw_bus_monitor.sv
// Concurrent checks on the two-wire link between controller and memory slave
`timescale 1ns/10ps
module tw_bus_monitor (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n
);
	// Bit position in a word, cycles since last clock rise, previous line levels
	typedef struct packed {
		logic [3:0] bit_cnt;
		logic [7:0] gap;
		logic       scl_p;
		logic       sda_p;
	} tw_mon_state_type;

	tw_mon_state_type st_q;
	tw_mon_state_type st_d;
	logic          start_seen;
	logic          stop_seen;

	// Bus conditions: data moves while the clock stays high
	assign start_seen = scl & st_q.scl_p & st_q.sda_p & ~sda;
	assign stop_seen  = scl & st_q.scl_p & ~st_q.sda_p & sda;

	// Count wraps after the ninth clock, so 8 marks the ack slot
	always_comb begin
		st_d = st_q;
		st_d.scl_p = scl;
		st_d.sda_p = sda;
		if (scl & ~st_q.scl_p) begin
			st_d.bit_cnt = (st_q.bit_cnt == 4'h8) ? 4'h0 : st_q.bit_cnt + 4'h1;
			st_d.gap = 8'h01;
		end else if (st_q.gap != 8'hff) begin
			st_d.gap = st_q.gap + 8'h01;
		end
		if (start_seen | stop_seen) begin
			st_d.bit_cnt = 4'h0;
		end
	end

	// Gap saturates so the first rise after reset is never judged
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= '{bit_cnt: 4'h0, gap: 8'hff, scl_p: 1'b1, sda_p: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	od_dev_a: assert property (!dev_sda_o) else $error("slave drives data line high");
	od_host_a: assert property (!host_sda_o) else $error("controller drives data line high");
	dev_edge_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
		else $error("slave moved data line while clock high");
	host_edge_a: assert property (scl && $past(scl) && $changed(host_sda_oe_n) |-> start_seen || stop_seen)
		else $error("controller moved data line while clock high outside start or stop");
	ack_start_a: assert property ($fell(dev_sda_oe_n) |-> !scl && st_q.bit_cnt == 4'h8)
		else $error("acknowledge begins outside the low after the eighth bit");
	ack_end_a: assert property ($rose(dev_sda_oe_n) |-> !scl && st_q.bit_cnt == 4'h0)
		else $error("acknowledge released outside the low after the ninth clock");
	ack_len_a: assert property ($fell(dev_sda_oe_n) |=> $stable(dev_sda_oe_n) [*8] ##[40:70] $rose(dev_sda_oe_n))
		else $error("acknowledge length wrong");
	scl_rate_a: assert property ($rose(scl) |-> st_q.gap >= 8'h3f)
		else $error("serial clock faster than allowed");
	reset_idle_a: assert property ($fell(srst) |-> scl && host_sda_oe_n && dev_sda_oe_n)
		else $error("link not idle after reset");

	start_c: cover property (start_seen);
	stop_c: cover property (stop_seen);
	ack_c: cover property ($fell(dev_sda_oe_n));
endmodule

// File: testbench/tb.sv
// Self-checking bench joining the controller and the memory slave
`timescale 1ns/10ps
module tb;
	import tw_pkg::*;
	localparam int WR = 2000;

	logic             sys_clk = 1'b0;
	logic             srst = 1'b1;
	logic             op_valid = 1'b0;
	tw_op_type        op_kind = OP_WRITE;
	logic [2:0]       op_sel = 3'h0;
	logic [13:0]      op_addr = 14'h0;
	logic [7:0]       op_count = 8'h0;
	logic [7:0]       wr_data;
	logic [2:0]       device_select_pins = 3'h5;
	logic             write_protect = 1'b0;
	logic             op_ready, data_take, op_done, op_nack;
	logic             prog_valid, busy;
	logic [13:0]      prog_addr;
	logic [7:0]       prog_data;
	logic [7:0]       dat [0:3] = '{8'h5a, 8'hc3, 8'h3c, 8'h96};
	int               di = 0;
	int               error_cnt = 0;
	int               checks = 0;
	int               cyc = 0;
	int               busy_run = 0;
	int               busy_last = 0;
	logic [13:0]      pa [$];
	logic [7:0]       pd [$];

	tw_bus_if bus_if ();
	tw_host #(.QTR_CYC(16)) tw_host_inst (.sys_clk(sys_clk), .srst(srst), .bus(bus_if), .op_valid(op_valid),
		.op_kind(op_kind), .op_sel(op_sel), .op_addr(op_addr), .op_count(op_count), .wr_data(wr_data),
		.op_ready(op_ready), .data_take(data_take), .op_done(op_done), .op_nack(op_nack));
	tw_device #(.WR_CYC(WR)) tw_device_inst (.sys_clk(sys_clk), .srst(srst), .bus(bus_if),
		.device_select_pins(device_select_pins), .write_protect(write_protect), .prog_valid(prog_valid),
		.prog_addr(prog_addr), .prog_data(prog_data), .busy(busy));
	tw_bus_monitor tw_bus_monitor_inst (.sys_clk(sys_clk), .srst(srst), .scl(bus_if.scl), .sda(bus_if.sda),
		.host_sda_o(bus_if.host_sda_o), .host_sda_oe_n(bus_if.host_sda_oe_n),
		.dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe_n(bus_if.dev_sda_oe_n));

	always #20 sys_clk = ~sys_clk;

	// Next byte is offered as soon as the controller has taken one
	assign wr_data = dat[di[1:0]];
	always @(posedge sys_clk) begin
		if (data_take === 1'b1) begin
			di <= di + 1;
		end
	end

	// Busy run length counted from its first high cycle, kept when it falls
	always @(posedge sys_clk) begin
		if (busy === 1'b1) begin
			busy_run <= busy_run + 1;
		end else begin
			if (busy_run != 0) begin
				busy_last <= busy_run;
			end
			busy_run <= 0;
		end
	end

	// Record every committed byte for later comparison
	always @(negedge sys_clk) begin
		if (prog_valid === 1'b1) begin
			pa.push_back(prog_addr);
			pd.push_back(prog_data);
		end
	end

	task automatic end_of_test();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic run_op(input tw_op_type k, input logic [2:0] s, input logic [13:0] a, input logic [7:0] n,
		output logic nk);
		@(posedge sys_clk);
		op_valid <= 1'b1;
		op_kind <= k;
		op_sel <= s;
		op_addr <= a;
		op_count <= n;
		di <= 0;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		// Only a new write clears the record; a poll must not lose bytes still being committed
		if (k == OP_WRITE) begin
			pa.delete();
			pd.delete();
		end
		for (int i = 0; i < 10000 && op_done !== 1'b1; i++) @(negedge sys_clk);
		// An operation that never finishes ends the run as a failure
		if (op_done !== 1'b1) begin
			error_cnt++;
			end_of_test();
		end
		check(op_ready, 1'b1);
		nk = op_nack;
	endtask

	// Length of the busy period after a stop, zero if none starts
	task automatic busy_len(output int len);
		len = 0;
		for (int i = 0; i < 12 && busy !== 1'b1; i++) @(negedge sys_clk);
		// Busy rises before the controller reports done, so the background count is used
		if (busy === 1'b1) begin
			for (int i = 0; i < WR + 100 && busy === 1'b1; i++) @(negedge sys_clk);
			@(negedge sys_clk);
			len = (busy === 1'b1) ? busy_run : busy_last;
		end
	endtask

	task automatic s_byte(input logic [2:0] s, input logic [13:0] a);
		logic nk;
		int   len;
		@(posedge sys_clk);
		device_select_pins <= s;
		repeat (4) @(posedge sys_clk);
		run_op(OP_WRITE, s, a, 8'h1, nk);
		check(nk, 1'b0);
		busy_len(len);
		check(len, WR);
		check(pa.size(), 1);
		check(pa[0], a);
		check(pd[0], dat[0]);
	endtask

	// Page write across the page end, then polls during and after the write cycle
	task automatic s_page();
		logic nk;
		int   len;
		run_op(OP_WRITE, 3'h5, 14'h1a7e, 8'h3, nk);
		check(nk, 1'b0);
		run_op(OP_POLL, 3'h5, 14'h0, 8'h0, nk);
		check(nk, 1'b1);
		check(pa.size(), 3);
		check(pa[0], 14'h1a40);
		check(pd[0], dat[2]);
		check(pa[1], 14'h1a7e);
		check(pd[1], dat[0]);
		check(pa[2], 14'h1a7f);
		check(pd[2], dat[1]);
		busy_len(len);
		run_op(OP_POLL, 3'h5, 14'h0, 8'h0, nk);
		check(nk, 1'b0);
	endtask

	// Wrong select bits, then a protected write: neither may start a write cycle
	task automatic s_refuse();
		logic nk;
		int   len;
		run_op(OP_WRITE, 3'h7, 14'h0123, 8'h1, nk);
		check(nk, 1'b1);
		busy_len(len);
		check(len, 0);
		@(posedge sys_clk);
		write_protect <= 1'b1;
		run_op(OP_WRITE, 3'h5, 14'h0123, 8'h1, nk);
		check(nk, 1'b0);
		busy_len(len);
		check(len, 0);
		check(pa.size(), 0);
		@(posedge sys_clk);
		write_protect <= 1'b0;
	endtask

	task automatic s_recover();
		logic nk;
		run_op(OP_RECOVER, 3'h5, 14'h0, 8'h0, nk);
		check(nk, 1'b0);
		s_byte(3'h2, 14'h3fc1);
	endtask

	initial begin
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		s_byte(3'h5, 14'h2a55);
		s_page();
		s_refuse();
		s_recover();
		end_of_test();
	end
endmodule
